// *** ipb_top.sv ***
// Our own choice: strobed register access.
`timescale 1ns/100ps
module ipb_top #(
	parameter int CH = ipb_pkg::IPB_CH_PER_FRAME
) (
	input  wire logic       clk,          // 40 MHz system clock
	input  wire logic       arst_n,       // Async reset, active low
	input  wire logic [7:0] reg_addr,     // Register address
	input  wire logic [7:0] reg_wdata,    // Register write data
	input  wire logic       reg_wr,       // Register write strobe
	input  wire logic       reg_rd,       // Register read strobe
	output logic      [7:0] reg_rdata,    // Register read data
	input  wire logic [7:0] pcm_in_data,  // Channel byte from store
	input  wire logic       pcm_in_valid, // Channel byte offered
	output logic            pcm_in_ready, // Buffer accepts byte
	input  wire logic       bus_bit_tick, // One pulse per bus bit
	input  wire logic       fsync_in,     // Frame sync pin, input
	output logic            fsync_out,    // Frame sync pin, output
	output logic            fsync_oe_n,   // Frame sync drive, low on
	output logic            pcm_out,      // Bus data pin, output
	output logic            pcm_oe_n      // Bus data drive, low on
);
	import ipb_pkg::*;

	localparam int CHL = $clog2(CH);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		ipb_state_e st;
		logic [2:0] bitn;
		logic [7:0] slot;
		logic [7:0] sh;
		logic       own;
		logic       pcm;
		logic       pcm_oe_n;
		logic       fs;
		logic       fs_oe_n;
		logic       fs_prev;
	} ipb_main_s;

	ipb_main_s  s_q;
	ipb_main_s  s_d;
	logic [7:0] ctrl;
	logic       sync_drive;
	logic [7:0] buf_data;
	logic       buf_valid;
	logic       buf_pop;
	logic       underrun;
	logic [2:0] pos;
	logic       en;
	logic       frame_mode;
	logic [1:0] size;
	logic [1:0] nlog;
	logic       size_ok;
	logic       master;
	logic       sync_edge;
	logic [7:0] slot_last;
	logic       own_now;
	logic [7:0] byte_now;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------

	// Turn decode: channel mode by low slot bits, frame mode by block
	function automatic logic ipb_owns(input logic [7:0] slot,
	                                  input logic [2:0] p,
	                                  input logic [1:0] nl,
	                                  input logic       fm);
		logic [7:0] mask;
		logic [7:0] blk;
		mask = 8'((9'h001 << nl) - 9'h001);
		blk  = slot >> CHL;
		if (fm) begin
			ipb_owns = (blk == ({5'h00, p} & mask));
		end else begin
			ipb_owns = ((slot & mask) == ({5'h00, p} & mask));
		end
	endfunction

	// Size code to log2 of device count
	function automatic logic [1:0] ipb_size_log(input logic [1:0] code);
		case (code)
			IPB_SIZE_TWO:   ipb_size_log = 2'h1;
			IPB_SIZE_FOUR:  ipb_size_log = 2'h2;
			IPB_SIZE_EIGHT: ipb_size_log = 2'h3;
			default:        ipb_size_log = 2'h0;
		endcase
	endfunction

	// ------------------------------------------------------------------
	// Register file and input buffer
	// ------------------------------------------------------------------
	ipb_regs u_regs (
		.clk        (clk),
		.arst_n     (arst_n),
		.reg_addr   (reg_addr),
		.reg_wdata  (reg_wdata),
		.reg_wr     (reg_wr),
		.reg_rd     (reg_rd),
		.reg_rdata  (reg_rdata),
		.running    (s_q.st == IPB_ST_RUN),
		.underrun   (underrun),
		.ctrl       (ctrl),
		.sync_drive (sync_drive)
	);

	ipb_fifo #(
		.W     (8),
		.DEPTH (IPB_BUF_DEPTH)
	) u_buf (
		.clk       (clk),
		.arst_n    (arst_n),
		.in_data   (pcm_in_data),
		.in_valid  (pcm_in_valid),
		.in_ready  (pcm_in_ready),
		.out_data  (buf_data),
		.out_valid (buf_valid),
		.out_ready (buf_pop)
	);

	// ------------------------------------------------------------------
	// Control decode
	// ------------------------------------------------------------------

	assign pos        = ctrl[IPB_POS_LSB +: 3];
	assign en         = ctrl[IPB_EN_BIT];
	assign frame_mode = ctrl[IPB_MODE_BIT];
	assign size       = ctrl[IPB_SIZE_LSB +: 2];
	assign nlog       = en ? ipb_size_log(size) : 2'h0;
	assign size_ok    = !en || (size != IPB_SIZE_RSVD);
	assign master     = sync_drive && (!en || pos == 3'h0);
	assign sync_edge  = !master && fsync_in && !s_q.fs_prev;
	assign slot_last  = 8'((CH << nlog) - 1);
	assign own_now    = size_ok && ipb_owns(s_q.slot, pos, nlog, frame_mode);
	assign byte_now   = buf_valid ? buf_data : IPB_IDLE_BYTE;
	assign buf_pop    = s_q.st == IPB_ST_RUN && bus_bit_tick &&
	                    s_q.bitn == 3'h0 && own_now;
	// empty slot sends idle and flags it
	assign underrun   = buf_pop && !buf_valid;

	// ------------------------------------------------------------------
	// Slot sequencer
	// ------------------------------------------------------------------
	always_comb begin
		s_d         = s_q;
		s_d.fs_prev = fsync_in;
		s_d.fs_oe_n = !master;
		case (s_q.st)
			IPB_ST_HUNT: begin
				s_d.pcm_oe_n = 1'b1;
				if (sync_edge || (master && bus_bit_tick)) begin
					s_d.st   = IPB_ST_RUN;
					s_d.bitn = 3'h0;
					s_d.slot = 8'h00;
				end
			end
			IPB_ST_RUN: begin
				if (sync_edge) begin
					// Realign to the common frame start
					s_d.bitn     = 3'h0;
					s_d.slot     = 8'h00;
					s_d.pcm_oe_n = 1'b1;
				end else if (bus_bit_tick) begin
					s_d.fs = master && s_q.bitn == 3'h0 && s_q.slot == 8'h00;
					if (s_q.bitn == 3'h0) begin
						s_d.own = own_now;
						s_d.pcm = byte_now[7];
						s_d.sh  = {byte_now[6:0], 1'b0};
					end else begin
						s_d.pcm = s_q.sh[7];
						s_d.sh  = {s_q.sh[6:0], 1'b0};
					end
					s_d.pcm_oe_n = (s_q.bitn == 3'h0) ? !own_now : !s_q.own;
					s_d.bitn     = 3'(s_q.bitn + 3'h1);
					if (s_q.bitn == 3'h7) begin
						s_d.slot = (s_q.slot >= slot_last) ? 8'h00
						         : 8'(s_q.slot + 8'h01);
					end
				end
			end
			default: begin
				s_d.st       = IPB_ST_HUNT;
				s_d.pcm_oe_n = 1'b1;
			end
		endcase
		if (!master) begin
			s_d.fs = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= '{st: IPB_ST_HUNT, bitn: 3'h0, slot: 8'h00, sh: 8'h00,
			         own: 1'b0, pcm: 1'b0, pcm_oe_n: 1'b1, fs: 1'b0,
			         fs_oe_n: 1'b1, fs_prev: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign pcm_out    = s_q.pcm;
	assign pcm_oe_n   = s_q.pcm_oe_n;
	assign fsync_out  = s_q.fs;
	assign fsync_oe_n = s_q.fs_oe_n;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	sequence s_slot_start;
		s_q.st == IPB_ST_RUN && bus_bit_tick && !sync_edge &&
		s_q.bitn == 3'h0;
	endsequence

	AST_DRIVE_ONLY_RUN: assert property (@(posedge clk) disable iff (!arst_n)
		!pcm_oe_n |-> s_q.st == IPB_ST_RUN)
		else $error("data line driven before frame lock");

	AST_RSVD_SILENT: assert property (@(posedge clk) disable iff (!arst_n)
		s_slot_start and (en && size == IPB_SIZE_RSVD) |=> pcm_oe_n)
		else $error("reserved bus size still drives");

	AST_CHAN_TURN: assert property (@(posedge clk) disable iff (!arst_n)
		s_slot_start and (en && !frame_mode && size == IPB_SIZE_FOUR &&
		s_q.slot[1:0] == pos[1:0]) |=> !pcm_oe_n)
		else $error("own channel slot not driven");

	AST_RELEASE: assert property (@(posedge clk) disable iff (!arst_n)
		s_slot_start and (en && !frame_mode && size == IPB_SIZE_FOUR &&
		s_q.slot[1:0] != pos[1:0]) |=> pcm_oe_n)
		else $error("foreign slot driven");

	AST_FRAME_TURN: assert property (@(posedge clk) disable iff (!arst_n)
		s_slot_start and (en && frame_mode && size == IPB_SIZE_EIGHT &&
		(s_q.slot >> CHL) == {5'h00, pos}) |=> !pcm_oe_n)
		else $error("own frame block not driven");

	AST_NORMAL: assert property (@(posedge clk) disable iff (!arst_n)
		s_slot_start and !en |=> !pcm_oe_n)
		else $error("normal mode slot not driven");

	AST_TWO_WRAP: assert property (@(posedge clk) disable iff (!arst_n)
		s_q.st == IPB_ST_RUN && bus_bit_tick && !sync_edge && en &&
		size == IPB_SIZE_TWO && s_q.bitn == 3'h7 &&
		s_q.slot == 8'(2 * CH - 1) |=> s_q.slot == 8'h00)
		else $error("two-device frame length wrong");

	AST_SYNC_ALIGN: assert property (@(posedge clk) disable iff (!arst_n)
		sync_edge |=> s_q.st == IPB_ST_RUN && s_q.bitn == 3'h0 &&
		s_q.slot == 8'h00)
		else $error("frame sync did not realign");

	AST_IDLE_FILL: assert property (@(posedge clk) disable iff (!arst_n)
		s_slot_start and (own_now && !buf_valid) |=> pcm_out ##1
		(!bus_bit_tick || pcm_out))
		else $error("empty slot not idle filled");

endmodule

// *** ipb_pkg.sv ***
package ipb_pkg;

	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	localparam logic [7:0] IPB_CTRL_ADDR = 8'hC5; // Interleave bus control
	localparam logic [7:0] IPB_SYNC_ADDR = 8'hC6; // Frame sync source
	localparam logic [7:0] IPB_STAT_ADDR = 8'hC7; // Block status

	// Control field positions
	localparam int IPB_POS_LSB  = 0;
	localparam int IPB_EN_BIT   = 3;
	localparam int IPB_MODE_BIT = 4;
	localparam int IPB_SIZE_LSB = 5;

	// Reset values and writable bits
	localparam logic [7:0] IPB_CTRL_RST  = 8'h00;
	localparam logic [7:0] IPB_CTRL_MASK = 8'h7F;
	localparam logic       IPB_SYNC_RST  = 1'b0;

	// Status field positions
	localparam int IPB_STAT_RUN_BIT = 0;
	localparam int IPB_STAT_UNF_BIT = 1;

	// Bus size codes
	localparam logic [1:0] IPB_SIZE_TWO   = 2'h0;
	localparam logic [1:0] IPB_SIZE_FOUR  = 2'h1;
	localparam logic [1:0] IPB_SIZE_EIGHT = 2'h2;
	localparam logic [1:0] IPB_SIZE_RSVD  = 2'h3;

	// ------------------------------------------------------------------
	// Frame layout
	// ------------------------------------------------------------------
	localparam int         IPB_CH_PER_FRAME = 32;
	localparam int         IPB_SLOT_BITS    = 8;
	localparam logic [7:0] IPB_IDLE_BYTE    = 8'hFF;
	localparam int         IPB_BUF_DEPTH    = 2;

	// Sequencer states
	typedef enum logic [1:0] {
		IPB_ST_HUNT = 2'h1,
		IPB_ST_RUN  = 2'h2
	} ipb_state_e;

endpackage

// *** ipb_fifo.sv ***
`timescale 1ns/100ps
module ipb_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = ipb_pkg::IPB_BUF_DEPTH
) (
	input  wire logic         clk,       // System clock
	input  wire logic         arst_n,    // Async reset, active low
	input  wire logic [W-1:0] in_data,   // Write data
	input  wire logic         in_valid,  // Write request
	output logic              in_ready,  // Space free
	output logic      [W-1:0] out_data,  // Head entry
	output logic              out_valid, // Entry present
	input  wire logic         out_ready  // Consumer takes head
);
	import ipb_pkg::*;

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [PW-1:0]           wp;
		logic [PW-1:0]           rp;
		logic [CW-1:0]           cnt;
		logic                    room;
	} ipb_fifo_s;

	// Empty buffer with room, so ready stands high in reset
	localparam ipb_fifo_s FIFO_RST = '{mem: '0, wp: '0, rp: '0, cnt: '0,
	                                   room: 1'b1};

	ipb_fifo_s s_q;
	ipb_fifo_s s_d;
	logic      push;
	logic      pop;

	// ------------------------------------------------------------------
	// Storage and pointers
	// ------------------------------------------------------------------
	always_comb begin
		s_d  = s_q;
		push = in_valid && s_q.room;
		pop  = out_ready && (s_q.cnt != '0);
		if (push) begin
			s_d.mem[s_q.wp] = in_data;
			s_d.wp = (s_q.wp == PW'(DEPTH - 1)) ? '0 : PW'(s_q.wp + 1'b1);
		end
		if (pop) begin
			s_d.rp = (s_q.rp == PW'(DEPTH - 1)) ? '0 : PW'(s_q.rp + 1'b1);
		end
		if (push && !pop) begin
			s_d.cnt = CW'(s_q.cnt + 1'b1);
		end else if (pop && !push) begin
			s_d.cnt = CW'(s_q.cnt - 1'b1);
		end
		s_d.room = (s_d.cnt != CW'(DEPTH));
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= FIFO_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// Ready is a flop; head data read straight from storage
	assign in_ready  = s_q.room;
	assign out_valid = (s_q.cnt != '0);
	assign out_data  = s_q.mem[s_q.rp];

endmodule

// *** ipb_regs.sv ***
`timescale 1ns/100ps
module ipb_regs (
	input  wire logic       clk,        // System clock
	input  wire logic       arst_n,     // Async reset, active low
	input  wire logic [7:0] reg_addr,   // Register address
	input  wire logic [7:0] reg_wdata,  // Write data
	input  wire logic       reg_wr,     // Write strobe
	input  wire logic       reg_rd,     // Read strobe
	output logic      [7:0] reg_rdata,  // Read data, cycle after strobe
	input  wire logic       running,    // Sequencer locked to frame
	input  wire logic       underrun,   // Slot had no data
	output logic      [7:0] ctrl,       // Control register
	output logic            sync_drive  // Frame sync source bit; top drives sync only when set and at position 0 or with interleave off
);
	import ipb_pkg::*;

	typedef struct packed {
		logic [7:0] ctrl;
		logic       sync;
		logic       unf;
		logic [7:0] rdata;
	} ipb_regs_s;

	ipb_regs_s s_q;
	ipb_regs_s s_d;

	// ------------------------------------------------------------------
	// Write, read and sticky status
	// ------------------------------------------------------------------
	always_comb begin
		s_d       = s_q;
		s_d.rdata = 8'h00;
		if (reg_wr && reg_addr == IPB_CTRL_ADDR) begin
			s_d.ctrl = reg_wdata & IPB_CTRL_MASK;
		end
		if (reg_wr && reg_addr == IPB_SYNC_ADDR) begin
			s_d.sync = reg_wdata[0];
		end
		if (reg_wr && reg_addr == IPB_STAT_ADDR && reg_wdata[IPB_STAT_UNF_BIT]) begin
			s_d.unf = 1'b0;
		end
		// Set beats a clear in the same cycle
		if (underrun) begin
			s_d.unf = 1'b1;
		end
		if (reg_rd) begin
			case (reg_addr)
				IPB_CTRL_ADDR: s_d.rdata = s_q.ctrl;
				IPB_SYNC_ADDR: s_d.rdata = {7'h00, s_q.sync};
				IPB_STAT_ADDR: s_d.rdata = {6'h00, s_q.unf, running};
				default:       s_d.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= '{ctrl: IPB_CTRL_RST, sync: IPB_SYNC_RST,
			         unf: 1'b0, rdata: 8'h00};
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata  = s_q.rdata;
	assign ctrl       = s_q.ctrl;
	assign sync_drive = s_q.sync;

endmodule

// *** ipb_peer.sv ***
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Backplane side: bit strobe, frame sync, pulled-up data line
// ----------------------------------------------------------------
module ipb_peer (
	input  wire logic        clk,        // System clock
	input  wire logic        run,        // Bus clocking on
	input  wire logic [10:0] frame_bits, // Bits per frame
	input  wire logic        pcm_out,    // Device data value
	input  wire logic        pcm_oe_n,   // Device drive, low on
	output logic             bit_tick,   // One pulse per bus bit
	output logic             fsync,      // Frame sync to device
	output logic             bus_wire    // Resolved data line
);
	logic [1:0]  cnt_q;
	logic [10:0] bit_q;

	// Bit and frame counters, cleared to zero and held there while stopped
	// one clock for all
	always @(posedge clk) begin
		if (!run) begin
			cnt_q <= 2'h0;
			bit_q <= 11'h000;
		end else begin
			cnt_q <= cnt_q + 2'h1;
			if (bit_tick)
				bit_q <= (bit_q == frame_bits - 11'h001) ? 11'h000
				                                         : bit_q + 11'h001;
		end
	end

	assign bit_tick = run && cnt_q == 2'h3;
	// sync from backplane at bit 0
	assign fsync = run && bit_q == 11'h000 && !cnt_q[1];
	assign bus_wire = pcm_oe_n ? 1'b1 : pcm_out;
endmodule

// *** ipb_top_test.sv ***
`timescale 1ns/100ps
`define IPB_CHK(nm, ex, got) begin num_checks++; \
	if ((got) !== (ex)) begin n_mismatch++; \
	$display("Error %s exp %h got %h", nm, ex, got); end end
module ipb_top_test;
	import ipb_pkg::*;
	localparam int CHN = 4;
	logic        clk, arst_n, reg_wr, reg_rd, pcm_in_valid, pcm_in_ready;
	logic        bus_bit_tick, fsync_in, fsync_out, fsync_oe_n, peer_fs;
	logic        pcm_out, pcm_oe_n, bus_wire, run, feed, arm, act;
	logic        tick_d, fs_d;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, pcm_in_data, cfg, sh, oe, st;
	logic [10:0] fbits;
	logic [31:0] lfsr;
	logic [7:0]  expq[$];
	int          n_mismatch, num_checks, nfr, idx;

	ipb_top #(.CH(CHN)) ipb_top_inst (.clk(clk), .arst_n(arst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .pcm_in_data(pcm_in_data),
		.pcm_in_valid(pcm_in_valid), .pcm_in_ready(pcm_in_ready),
		.bus_bit_tick(bus_bit_tick), .fsync_in(fsync_in),
		.fsync_out(fsync_out), .fsync_oe_n(fsync_oe_n), .pcm_out(pcm_out),
		.pcm_oe_n(pcm_oe_n));
	ipb_peer ipb_peer_inst (.clk(clk), .run(run), .frame_bits(fbits),
		.pcm_out(pcm_out), .pcm_oe_n(pcm_oe_n), .bit_tick(bus_bit_tick),
		.fsync(peer_fs), .bus_wire(bus_wire));

	// Sync pin level from whichever side drives it
	assign fsync_in = fsync_oe_n ? peer_fs : fsync_out;

	// 40 MHz clock
	always #12.5 clk = ~clk;

	// ----------------------------------------------------------------
	// Expectation helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic int dev_count(input logic [7:0] c);
		if (!c[IPB_EN_BIT])
			return 1;
		return 2 << ((c[6:5] == 2'h3) ? 2 : c[6:5]);
	endfunction

	function automatic logic owns(input logic [7:0] c, input int s);
		int n;
		n = dev_count(c);
		if (!c[IPB_EN_BIT])
			return 1'b1;
		if (c[6:5] == IPB_SIZE_RSVD)
			return 1'b0;
		if (c[IPB_MODE_BIT])
			return (s / CHN) == (c[2:0] % n);
		return (s % n) == (c[2:0] % n);
	endfunction

	// ----------------------------------------------------------------
	// Bus tasks and slot checks
	// ----------------------------------------------------------------
	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		d = reg_rdata;
	endtask

	task automatic do_reset();
		@(posedge clk);
		arst_n <= 1'b0;
		run    <= 1'b0;
		feed   <= 1'b0;
		arm    <= 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		expq.delete();
	endtask

	task automatic check_slot(input int s);
		logic [7:0] ex;
		if (owns(cfg, s)) begin
			ex = expq.size() ? expq.pop_front() : IPB_IDLE_BYTE;
			`IPB_CHK("own slot drive", 8'hFF, oe)
			`IPB_CHK("own slot data", ex, sh)
		end else
			`IPB_CHK("foreign slot", 8'h00, oe)
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Store side offers random bytes, records what the buffer takes
	always @(posedge clk) begin
		if (arst_n && pcm_in_valid && pcm_in_ready) begin
			expq.push_back(pcm_in_data);
			lfsr = lfsr_next(lfsr);
			pcm_in_data <= lfsr[7:0];
		end
		pcm_in_valid <= feed;
	end

	// Bus monitor: one bit per strobe, framed by the sync edge
	always @(posedge clk) begin
		tick_d <= bus_bit_tick;
		fs_d   <= fsync_in;
		if (tick_d && act && arm) begin
			sh = {sh[6:0], bus_wire};
			oe = {oe[6:0], ~pcm_oe_n};
			if (idx % 8 == 7)
				check_slot(idx / 8);
			idx++;
		end
		if (fsync_in && !fs_d) begin
			idx = 0;
			nfr++;
			act = arm;
		end
	end

	// Watchdog
	initial begin
		#1500000;
		n_mismatch++;
		end_sim();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{clk, arst_n, reg_wr, reg_rd, pcm_in_valid, run, feed} = '0;
		{arm, act, tick_d, fs_d, reg_addr, reg_wdata, pcm_in_data} = '0;
		{n_mismatch, num_checks, nfr, idx} = '0;
		fbits = 11'h020;
		lfsr = 32'h6422;
		for (int i = 0; i < 8; i++) begin
			do_reset();
			reg_read(IPB_CTRL_ADDR, st);
			`IPB_CHK("ctrl reset", IPB_CTRL_RST, st)
			lfsr = lfsr_next(lfsr);
			cfg = {1'b0, (i == 7) ? 2'h3 : 2'((i + 2) % 3), i > 3, i != 0,
			       lfsr[2:0]};
			reg_write(IPB_CTRL_ADDR, cfg);
			reg_read(IPB_CTRL_ADDR, st);
			`IPB_CHK("ctrl readback", cfg, st)
			fbits = 11'(CHN * 8 * dev_count(cfg));
			// store feeds while the bus stands still
			@(posedge clk);
			feed <= 1'b1;
			repeat (5) @(negedge clk);
			`IPB_CHK("fill refuse", 1'b0, pcm_in_ready)
			`IPB_CHK("fill count", 2, expq.size())
			`IPB_CHK("idle before sync", 1'b1, pcm_oe_n)
			@(posedge clk);
			feed <= (i != 5);
			arm  <= 1'b1;
			run  <= 1'b1;
			nfr = 0;
			for (int k = 0; k < 4000 && nfr < 3; k++)
				@(posedge clk);
			`IPB_CHK("frames seen", 3, nfr)
			reg_read(IPB_STAT_ADDR, st);
			`IPB_CHK("status", {i == 5, 1'b1}, st[1:0])
			// Stop the bus, then clear the sticky underrun flag
			if (i == 5) begin
				@(posedge clk);
				run <= 1'b0;
				reg_write(IPB_STAT_ADDR, 8'h02);
				reg_read(IPB_STAT_ADDR, st);
				`IPB_CHK("status clear", 8'h01, st)
			end
			`IPB_CHK("sync pin input", 1'b1, fsync_oe_n)
		end
		do_reset();
		reg_write(IPB_CTRL_ADDR, 8'h48);
		reg_write(IPB_SYNC_ADDR, 8'h01);
		@(posedge clk);
		run <= 1'b1;
		for (int k = 0; k < 3000 && fsync_out !== 1'b1; k++)
			@(negedge clk);
		`IPB_CHK("sync master pulse", 1'b1, fsync_out)
		`IPB_CHK("sync master drive", 1'b0, fsync_oe_n)
		reg_read(8'h10, st);
		`IPB_CHK("unmapped read", 8'h00, st)
		end_sim();
	end
endmodule
